// *** verilog/modtm_timer.sv ***
// modulo timer: 8-bit counter, prescaler, clock select, AXI4-Lite slave
// Operation
// [R1] 8-bit up-counter, free-running or limited by programmable modulo value.
// [R2] four clock inputs: bus, fixed-frequency, pin rising, pin falling.
// [R3] nine prescale ratios, powers of two from 1 to 256.
// [R4] external pin feeds prescaler when clock-select holds either upper code.
// [R5] counting continues in wait mode when enabled before entry.
// [R6] all stop modes halt the timer; never a stop wake-up source.
// [R7] deep stop wake, or light stop left by reset, restores reset state.
// [R8] light stop left by interrupt keeps state and resumes held count.
// [R9] debug halt suspends counting; resumes unless reset or modulo write.
// [R10] pin synchronised to bus clock; source at most quarter bus rate.
// [R11] overflow flag in bit 7 sets when count wraps from modulo to zero.
// [R12] flag cleared by read while set, then write of zero.
// [R13] counter-reset write of one or any modulo write also clears flag.
// [R14] interrupt requested when flag and enable (bit 6) both set.
// [R15] software clears flag before setting interrupt enable.
// [R16] counter-reset bit 5 write one zeroes count; reads zero.
// [R17] stop bit 4 freezes count; reset sets it.
// [R18] status bits 3:0 and clock-config bits 7:6 read zero.
// [R19] clock select 00 bus, 01 fixed, 10 pin fall, 11 pin rise.
// [R20] prescale code n divides by 2^n; codes above 8 divide by 256.
// [R21] count wraps after equal nonzero modulo; zero modulo wraps at 255.
// [R22] changing clock source or prescale keeps the count.
// [R23] interrupt output is level AND of flag and enable.
// [R24] pin passes two-stage synchroniser then edge detector.
//
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`default_nettype none
module modtm_timer
#(
   parameter int CNT_W = 8,
   parameter int PS_W  = 8
)
(
   input  wire logic              ref_clk,
   input  wire logic              reset_n,
   input  wire logic              fixedClkTick,
   input  wire logic              extTimerClkPin,
   input  wire logic              stopMode,
   input  wire logic              stopDeepWake,
   input  wire logic              stopLightResetExit,
   input  wire logic              debugHalt,
   output logic                   overflowIrq,
   input  wire logic [3:0]        s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [3:0]        s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready
);

   // ************************************************************
   // write channel capture
   // ************************************************************
   logic             awHeld_reg;
   logic [3:0]       awAddr_reg;
   logic             wHeld_reg;
   logic [7:0]       wData_reg;
   logic             wByte0_reg;
   logic             bValid_reg;
   logic [1:0]       bResp_reg;
   logic             arValid_reg;
   logic [31:0]      rData_reg;
   logic [1:0]       rResp_reg;

   wire              awTake  = s_axi_awvalid && !awHeld_reg && !bValid_reg;
   wire              wTake   = s_axi_wvalid && !wHeld_reg && !bValid_reg;
   wire              wrFire  = awHeld_reg && wHeld_reg && !bValid_reg;
   wire              arTake  = s_axi_arvalid && !arValid_reg;

   assign s_axi_awready = !awHeld_reg && !bValid_reg;
   assign s_axi_wready  = !wHeld_reg && !bValid_reg;
   assign s_axi_bvalid  = bValid_reg;
   assign s_axi_bresp   = bResp_reg;
   assign s_axi_arready = !arValid_reg;
   assign s_axi_rvalid  = arValid_reg;
   assign s_axi_rdata   = rData_reg;
   assign s_axi_rresp   = rResp_reg;

   function automatic logic isMapped(input logic [3:0] addr);
      isMapped = (addr == modtm_pkg::OFS_STATUS_CONTROL) ||
                 (addr == modtm_pkg::OFS_CLOCK_CONFIG)   ||
                 (addr == modtm_pkg::OFS_COUNT_VALUE)    ||
                 (addr == modtm_pkg::OFS_MODULO_LIMIT);
   endfunction

   wire              wrEnable = wrFire && wByte0_reg;
   wire              wrStatus = wrEnable && (awAddr_reg == modtm_pkg::OFS_STATUS_CONTROL);
   wire              wrClock  = wrEnable && (awAddr_reg == modtm_pkg::OFS_CLOCK_CONFIG);
   wire              wrModulo = wrEnable && (awAddr_reg == modtm_pkg::OFS_MODULO_LIMIT);
   wire              rdStatus = arTake && (s_axi_araddr == modtm_pkg::OFS_STATUS_CONTROL);

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         awHeld_reg <= 1'b0;
         awAddr_reg <= 4'h0;
         wHeld_reg  <= 1'b0;
         wData_reg  <= 8'h00;
         wByte0_reg <= 1'b0;
      end
      else
      begin
         if (awTake)
         begin
            awHeld_reg <= 1'b1;
            awAddr_reg <= {s_axi_awaddr[3:2], 2'b00};
         end
         else if (wrFire)
            awHeld_reg <= 1'b0;
         if (wTake)
         begin
            wHeld_reg  <= 1'b1;
            wData_reg  <= s_axi_wdata[7:0];
            wByte0_reg <= s_axi_wstrb[0];
         end
         else if (wrFire)
            wHeld_reg <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         bValid_reg <= 1'b0;
         bResp_reg  <= modtm_pkg::RESP_OKAY;
      end
      else if (wrFire)
      begin
         bValid_reg <= 1'b1;
         bResp_reg  <= isMapped(awAddr_reg) ? modtm_pkg::RESP_OKAY : modtm_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
         bValid_reg <= 1'b0;
   end

   // ************************************************************
   // timer registers
   // ************************************************************
   logic [CNT_W-1:0] count_reg;
   logic [CNT_W-1:0] modulo_reg;
   logic             ovfFlag_reg;
   logic             ovfArmed_reg;
   logic             ovfIe_reg;
   logic             stop_reg;
   logic [1:0]       clkSel_reg;
   logic [3:0]       prescale_reg;
   logic [PS_W-1:0]  psCnt_reg;
   logic             pinSync1_reg;
   logic             pinSync2_reg;
   logic             pinPrev_reg;

   // deep stop wake or reset exit from light stop returns to reset state
   wire              softReset = stopDeepWake || stopLightResetExit;                 // R7

   // second stage only feeds the edge detector
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pinSync1_reg <= 1'b0;
         pinSync2_reg <= 1'b0;
         pinPrev_reg  <= 1'b0;
      end
      else
      begin
         pinSync1_reg <= extTimerClkPin;                                             // R10
         pinSync2_reg <= pinSync1_reg;                                               // R24
         pinPrev_reg  <= pinSync2_reg;
      end
   end

   wire              pinRise = pinSync2_reg && !pinPrev_reg;                         // R24
   wire              pinFall = !pinSync2_reg && pinPrev_reg;

   // clock source edge pulse
   wire              srcTick =                                                       // R2
      (clkSel_reg == modtm_pkg::CLOCK_SELECT_FIELD_BUS)      ? 1'b1 :                              // R19
      (clkSel_reg == modtm_pkg::CLOCK_SELECT_FIELD_FIXED)    ? fixedClkTick :
      (clkSel_reg == modtm_pkg::CLOCK_SELECT_FIELD_EXT_FALL) ? pinFall : pinRise;                  // R4

   // stop mode and debug halt freeze prescaler and counting, wait mode does not
   wire              runEn   = !stop_reg && !stopMode && !debugHalt;                 // R5 R6 R9 R17

   wire [3:0]        psSel   = (prescale_reg > modtm_pkg::PS_MAX) ? modtm_pkg::PS_MAX
                                                                  : prescale_reg;    // R20
   wire [PS_W:0]     psMask  = (PS_W+1)'((1 << psSel) - 1);                          // R3
   wire              psDone  = (({1'b0, psCnt_reg} & psMask) == psMask);
   wire              cntTick = runEn && srcTick && psDone;

   wire [CNT_W-1:0]  topVal  = (modulo_reg == modtm_pkg::FREE_RUN_MOD)
                               ? modtm_pkg::FREE_RUN_TOP : modulo_reg;               // R21
   wire              wrapNow = cntTick && (count_reg == topVal);                     // R1
   wire              cntRst  = wrStatus && wData_reg[modtm_pkg::BIT_CNT_RST];        // R16
   wire              flagClr = (wrStatus && ovfArmed_reg && !wData_reg[modtm_pkg::BIT_OVF])
                               || cntRst || wrModulo;                                // R12 R13

   // prescaler keeps running across source/ratio changes: count is untouched
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         psCnt_reg <= '0;
      else if (softReset || cntRst || wrModulo)
         psCnt_reg <= '0;
      else if (runEn && srcTick)
         psCnt_reg <= psCnt_reg + 1'b1;                                              // R22
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         count_reg <= modtm_pkg::COUNT_RESET;
      else if (softReset || cntRst || wrModulo)
         count_reg <= modtm_pkg::COUNT_RESET;                                        // R9 R16
      else if (wrapNow)
         count_reg <= modtm_pkg::COUNT_RESET;                                        // R21
      else if (cntTick)
         count_reg <= count_reg + 1'b1;                                              // R8
   end

   // a fresh overflow wins over a software clear in the same cycle
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         ovfFlag_reg <= 1'b0;
      else if (softReset)
         ovfFlag_reg <= 1'b0;
      else if (wrapNow)
         ovfFlag_reg <= 1'b1;                                                        // R11
      else if (flagClr)
         ovfFlag_reg <= 1'b0;                                                        // R12
   end

   // armed by a status read while the flag is set, spent by next status write
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         ovfArmed_reg <= 1'b0;
      else if (softReset || wrStatus || !ovfFlag_reg)
         ovfArmed_reg <= 1'b0;
      else if (rdStatus)
         ovfArmed_reg <= 1'b1;                                                       // R12
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ovfIe_reg    <= 1'b0;
         stop_reg     <= 1'b1;
         clkSel_reg   <= modtm_pkg::CLOCK_SELECT_FIELD_BUS;
         prescale_reg <= 4'h0;
         modulo_reg   <= modtm_pkg::MODULO_RESET;
      end
      else if (softReset)
      begin
         ovfIe_reg    <= 1'b0;
         stop_reg     <= 1'b1;                                                       // R17
         clkSel_reg   <= modtm_pkg::CLOCK_SELECT_FIELD_BUS;                                        // R19
         prescale_reg <= 4'h0;                                                       // R20
         modulo_reg   <= modtm_pkg::MODULO_RESET;
      end
      else
      begin
         if (wrStatus)
         begin
            ovfIe_reg <= wData_reg[modtm_pkg::BIT_OVF_IE];                           // R14
            stop_reg  <= wData_reg[modtm_pkg::BIT_CNT_STOP];                         // R17
         end
         if (wrClock)
         begin
            clkSel_reg   <= wData_reg[modtm_pkg::CLOCK_SELECT_FIELD_HI:modtm_pkg::CLOCK_SELECT_FIELD_LO];
            prescale_reg <= wData_reg[modtm_pkg::PS_HI:modtm_pkg::PS_LO];
         end
         if (wrModulo)
            modulo_reg <= wData_reg;
      end
   end

   assign overflowIrq = ovfFlag_reg && ovfIe_reg;                                    // R14 R23

   // ************************************************************
   // read path
   // ************************************************************
   wire [7:0]        statusRd = {ovfFlag_reg, ovfIe_reg, 1'b0, stop_reg, 4'h0};      // R18
   wire [7:0]        clockRd  = {2'b00, clkSel_reg, prescale_reg} & modtm_pkg::CLK_CFG_MASK;
   wire [7:0]        rdByte   =
      (s_axi_araddr[3:2] == modtm_pkg::OFS_STATUS_CONTROL[3:2]) ? statusRd :
      (s_axi_araddr[3:2] == modtm_pkg::OFS_CLOCK_CONFIG[3:2])   ? clockRd  :
      (s_axi_araddr[3:2] == modtm_pkg::OFS_COUNT_VALUE[3:2])    ? count_reg :
      modulo_reg;

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         arValid_reg <= 1'b0;
         rData_reg   <= 32'h0000_0000;
         rResp_reg   <= modtm_pkg::RESP_OKAY;
      end
      else if (arTake)
      begin
         arValid_reg <= 1'b1;
         rData_reg   <= {24'h00_0000, rdByte};
         rResp_reg   <= modtm_pkg::RESP_OKAY;
      end
      else if (s_axi_rready)
         arValid_reg <= 1'b0;
   end

   // ************************************************************
   // checks
   // ************************************************************
   property p_wrap_sets_flag;
      @(posedge ref_clk) disable iff (!reset_n)
      (wrapNow && !softReset) |=> ovfFlag_reg && (count_reg == modtm_pkg::COUNT_RESET);
   endproperty
   a_wrap_sets_flag: assert property (p_wrap_sets_flag) else $error("wrap did not set flag"); // R11

   property p_stop_freezes;
      @(posedge ref_clk) disable iff (!reset_n)
      (!runEn && !softReset && !cntRst && !wrModulo) |=> $stable(count_reg);
   endproperty
   a_stop_freezes: assert property (p_stop_freezes) else $error("count moved while frozen"); // R17

   // request must hold until software or a reset source clears flag or enable
   property p_irq_level;
      @(posedge ref_clk) disable iff (!reset_n)
      (overflowIrq && !flagClr && !softReset && !wrStatus) |=> overflowIrq;
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("irq not flag and enable"); // R23

   property p_modwrite_clears;
      @(posedge ref_clk) disable iff (!reset_n)
      (wrModulo && !wrapNow) |=> !ovfFlag_reg && (count_reg == modtm_pkg::COUNT_RESET);
   endproperty
   a_modwrite_clears: assert property (p_modwrite_clears) else $error("modulo write no clear"); // R13

   property p_no_clear_unarmed;
      @(posedge ref_clk) disable iff (!reset_n)
      (ovfFlag_reg && wrStatus && !ovfArmed_reg && !cntRst && !softReset) |=> ovfFlag_reg;
   endproperty
   a_no_clear_unarmed: assert property (p_no_clear_unarmed) else $error("flag cleared unarmed"); // R12

   // watched on the bus itself, so a slip in the read mux is caught too
   property p_reserved_zero;
      @(posedge ref_clk) disable iff (!reset_n)
      $rose(s_axi_rvalid) |-> (s_axi_rdata[31:8] == 24'h00_0000)
         && (($past(s_axi_araddr) != modtm_pkg::OFS_STATUS_CONTROL)
             || ((s_axi_rdata[5] == 1'b0) && (s_axi_rdata[3:0] == 4'h0)))
         && (($past(s_axi_araddr) != modtm_pkg::OFS_CLOCK_CONFIG)
             || (s_axi_rdata[7:6] == 2'b00));
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero"); // R18

   property p_free_wrap;
      @(posedge ref_clk) disable iff (!reset_n)
      (cntTick && modulo_reg == modtm_pkg::FREE_RUN_MOD && count_reg != modtm_pkg::FREE_RUN_TOP
       && !softReset && !cntRst && !wrModulo) |=> !$stable(count_reg) && !$rose(ovfFlag_reg);
   endproperty
   a_free_wrap: assert property (p_free_wrap) else $error("free run wrapped early"); // R21

   property p_deep_reset;
      @(posedge ref_clk) disable iff (!reset_n)
      softReset |=> stop_reg && !ovfFlag_reg && (count_reg == modtm_pkg::COUNT_RESET)
                    && (modulo_reg == modtm_pkg::MODULO_RESET);
   endproperty
   a_deep_reset: assert property (p_deep_reset) else $error("stop wake not reset"); // R7

   property p_pin_edge;
      @(posedge ref_clk) disable iff (!reset_n)
      $rose(pinSync1_reg) |=> pinRise;
   endproperty
   a_pin_edge: assert property (p_pin_edge) else $error("pin edge missed"); // R24
endmodule
`default_nettype wire

// *** verilog/modtm_pkg.sv ***
// package: register map, field layout and constants of the modulo timer
`default_nettype none
package modtm_pkg;
   localparam logic [3:0] OFS_STATUS_CONTROL = 4'h0;
   localparam logic [3:0] OFS_CLOCK_CONFIG   = 4'h4;
   localparam logic [3:0] OFS_COUNT_VALUE    = 4'h8;
   localparam logic [3:0] OFS_MODULO_LIMIT   = 4'hC;
   localparam logic [3:0] OFS_POWER_CONTROL  = 4'h0;
   localparam int BIT_OVF       = 7;
   localparam int BIT_OVF_IE    = 6;
   localparam int BIT_CNT_RST   = 5;
   localparam int BIT_CNT_STOP  = 4;
   localparam int CLOCK_SELECT_FIELD_HI       = 5;
   localparam int CLOCK_SELECT_FIELD_LO       = 4;
   localparam int PS_HI         = 3;
   localparam int PS_LO         = 0;
   localparam logic [1:0] CLOCK_SELECT_FIELD_BUS      = 2'h0;
   localparam logic [1:0] CLOCK_SELECT_FIELD_FIXED    = 2'h1;
   localparam logic [1:0] CLOCK_SELECT_FIELD_EXT_FALL = 2'h2;
   localparam logic [1:0] CLOCK_SELECT_FIELD_EXT_RISE = 2'h3;
   localparam logic [3:0] PS_MAX        = 4'h8;
   localparam logic [7:0] COUNT_RESET   = 8'h00;
   localparam logic [7:0] MODULO_RESET  = 8'h00;
   localparam logic [7:0] FREE_RUN_MOD  = 8'h00;
   localparam logic [7:0] FREE_RUN_TOP  = 8'hFF;
   localparam logic [7:0] CLK_CFG_MASK  = 8'h3F;
   localparam logic [1:0] RESP_OKAY     = 2'h0;
   localparam logic [1:0] RESP_SLVERR   = 2'h2;

   typedef struct packed {
      logic [3:0] awaddr;
      logic [7:0] wdata;
      logic       wbyte0;
   } modtm_wreq_t;

   typedef struct packed {
      logic stopMode;
      logic wakeReset;
      logic debugHalt;
   } modtm_power_t;
endpackage
`default_nettype wire

// *** verif/modtm_ext_clk_src.sv ***
// behavioural source that drives the external timer clock pin
`default_nettype none
module modtm_ext_clk_src
#(
   parameter int HALF_NS = 35
)
(
   input  wire logic       ref_clk,
   input  wire logic       start,
   input  wire logic [7:0] numEdges,
   output logic            pin,
   output logic            busy
);
   timeunit 1ns;
   timeprecision 1ps;
   // half period over four bus cycles keeps the pin under a quarter of the bus rate
   initial
   begin
      pin = 1'b0;
      busy = 1'b0;
      forever
      begin
         @(posedge ref_clk iff start);
         busy = 1'b1;
         repeat (numEdges)
         begin
            #(HALF_NS) pin = 1'b1;
            #(HALF_NS) pin = 1'b0;
         end
         // pin rests low between bursts, no free-running clock
         #(HALF_NS) busy = 1'b0;
      end
   end
endmodule
`default_nettype wire

// *** verif/modulo_timer_8bit_tb.sv ***
// bench for the modulo timer: bus tasks, reference model and scenarios
`default_nettype none
module modulo_timer_8bit_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [3:0] ASt = modtm_pkg::OFS_STATUS_CONTROL;
   localparam logic [3:0] ACk = modtm_pkg::OFS_CLOCK_CONFIG;
   localparam logic [3:0] ACn = modtm_pkg::OFS_COUNT_VALUE;
   localparam logic [3:0] AMd = modtm_pkg::OFS_MODULO_LIMIT;
   logic        ref_clk, reset_n, fixedClkTick, extTimerClkPin, stopMode, debugHalt;
   logic        stopDeepWake, stopLightResetExit, overflowIrq, extStart, extBusy;
   logic [3:0]  awaddr, araddr, wstrb;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata, rd;
   logic [1:0]  bresp, rresp, mCk;
   logic [7:0]  extEdges;
   logic        mFlag, mIe, mStop, mArmed;
   int          num_errors, n_compared, seed, mCnt, mMod, mPs, mPre, n, i, w;

   modtm_timer dut_u
   (
      .ref_clk(ref_clk), .reset_n(reset_n), .fixedClkTick(fixedClkTick),
      .extTimerClkPin(extTimerClkPin), .stopMode(stopMode), .stopDeepWake(stopDeepWake),
      .stopLightResetExit(stopLightResetExit), .debugHalt(debugHalt),
      .overflowIrq(overflowIrq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
   );

   modtm_ext_clk_src ext_u
   (
      .ref_clk(ref_clk), .start(extStart), .numEdges(extEdges),
      .pin(extTimerClkPin), .busy(extBusy)
   );

   initial ref_clk = 1'b0;
   always #4 ref_clk = ~ref_clk;

   // ****************************************
   // checking, bus tasks and reference model
   // ****************************************
   task automatic end_of_test();
      $display("compares %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   task automatic stuck(input int t);
      if (t >= 100)
      begin
         num_errors++;
         end_of_test();
      end
   endtask

   task automatic axi_write(input logic [3:0] a, input logic [7:0] d);
      int t;
      t = 0;
      @(posedge ref_clk);
      awaddr <= a;
      wdata <= {24'h00_0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge ref_clk);
         t++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end
      while (!bvalid && t < 100);
      bready <= 1'b0;
      stuck(t);
   endtask

   task automatic axi_read(input logic [3:0] a, output logic [31:0] d);
      int t;
      t = 0;
      @(posedge ref_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge ref_clk);
         t++;
         if (arvalid && arready) arvalid <= 1'b0;
      end
      while (!rvalid && t < 100);
      d = rdata;
      rready <= 1'b0;
      stuck(t);
   endtask

   task automatic model_reset();
      mCnt = 0;
      mMod = 0;
      mPs = 0;
      mPre = 0;
      {mFlag, mIe, mArmed, mCk} = '0;
      mStop = 1'b1;
   endtask

   function automatic void step();
      if (mStop || stopMode || debugHalt)
         return;
      mPre++;
      if (mPre >= (1 << ((mPs > 8) ? 8 : mPs)))
      begin
         mPre = 0;
         mFlag = mFlag | (mCnt == ((mMod == 0) ? 255 : mMod));
         mCnt = (mCnt == ((mMod == 0) ? 255 : mMod)) ? 0 : mCnt + 1;
      end
   endfunction

   task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
      axi_write(a, d);
      if (a == ASt)
      begin
         // a clearing write only counts right after a status read that saw the flag
         mFlag = mFlag & !(mArmed && !d[7]);
         mArmed = 1'b0;
         mIe = d[6];
         mStop = d[4];
      end
      if (a == ACk)
      begin
         mCk = d[5:4];
         mPs = d[3:0];
      end
      if (a == AMd)
         mMod = d;
      // any clear of the flag also spends an earlier status read
      if ((a == ASt && d[5]) || a == AMd)
      begin
         mCnt = 0;
         mPre = 0;
         mFlag = 1'b0;
         mArmed = 1'b0;
      end
   endtask

   task automatic reg_read(input logic [3:0] a);
      logic [7:0] e;
      e = (a == ASt) ? {mFlag, mIe, 1'b0, mStop, 4'h0} : (a == ACk) ? {2'b00, mCk, 4'(mPs)}
        : (a == ACn) ? 8'(mCnt) : 8'(mMod);
      axi_read(a, rd);
      mArmed = mArmed | (a == ASt && mFlag);
      check(rd, {24'h00_0000, e});
   endtask

   task automatic tick(input int k);
      repeat (k)
      begin
         @(posedge ref_clk);
         fixedClkTick <= 1'b1;
         @(posedge ref_clk);
         fixedClkTick <= 1'b0;
         step();
      end
   endtask

   task automatic check_irq();
      repeat (2) @(posedge ref_clk);
      check({31'h0, overflowIrq}, {31'h0, mFlag & mIe});
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   initial
   begin
      seed = 32'hc7ce_dd0e;
      num_errors = 0;
      n_compared = 0;
      {reset_n, fixedClkTick, stopMode, stopDeepWake, stopLightResetExit} = '0;
      {debugHalt, extStart, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata, extEdges} = '0;
      wstrb = 4'hF;
      model_reset();
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'b1;
      for (i = 0; i < 4; i++) reg_read(4'(i * 4));
      reg_write(ACk, 8'hFF);
      reg_read(ACk);
      reg_write(ASt, 8'h3F);
      reg_read(ASt);
      reg_write(ACn, 8'h55);
      reg_read(ACn);
      $display("test registers done");
      for (i = 0; i < 11; i++)
      begin
         reg_write(ACk, {4'h1, 4'(i)});
         reg_write(AMd, (i == 10) ? 8'h00 : 8'h03);
         reg_write(ASt, 8'h00);
         n = (i == 10) ? 250 : (1 << ((i > 8) ? 8 : i)) * 5;
         tick(n + ($random(seed) & 32'h0000_000F));
         reg_read(ACn);
         reg_read(ASt);
         reg_write(ASt, 8'h10);
      end
      $display("test prescale and wrap done");
      reg_write(ACk, 8'h10);
      reg_write(AMd, 8'h02);
      reg_write(ASt, 8'h40);
      tick(3);
      check_irq();
      reg_write(ASt, 8'h40);
      reg_read(ASt);
      reg_write(ASt, 8'h40);
      reg_read(ASt);
      check_irq();
      tick(3);
      reg_write(ASt, 8'h00);
      check_irq();
      reg_write(ASt, 8'h20);
      reg_read(ASt);
      reg_read(ACn);
      tick(4);
      reg_write(AMd, 8'h02);
      reg_read(ASt);
      $display("test overflow flag done");
      reg_write(ASt, 8'h00);
      tick(1);
      stopMode <= 1'b1;
      tick(4);
      reg_read(ACn);
      stopMode <= 1'b0;
      tick(2);
      reg_read(ACn);
      debugHalt <= 1'b1;
      tick(3);
      reg_read(ACn);
      debugHalt <= 1'b0;
      tick(1);
      reg_read(ACn);
      debugHalt <= 1'b1;
      reg_write(AMd, 8'h07);
      debugHalt <= 1'b0;
      tick(2);
      reg_read(ACn);
      for (w = 1; w < 3; w++)
      begin
         reg_write(ACk, 8'h13);
         reg_write(ASt, 8'h40);
         {stopLightResetExit, stopDeepWake} <= 2'(w);
         @(posedge ref_clk);
         {stopLightResetExit, stopDeepWake} <= 2'b00;
         model_reset();
         for (i = 0; i < 4; i++) reg_read(4'(i * 4));
      end
      $display("test low power modes done");
      for (i = 2; i < 4; i++)
      begin
         reg_write(ACk, {2'b00, 2'(i), 4'h0});
         reg_write(AMd, 8'h00);
         reg_write(ASt, 8'h00);
         n = 1 + ($random(seed) & 32'h0000_000F);
         extEdges <= 8'(n);
         extStart <= 1'b1;
         @(posedge ref_clk);
         extStart <= 1'b0;
         @(posedge ref_clk);
         // a burst of 16 edges lasts about 145 bus cycles
         for (w = 0; extBusy && w < 99; w++) repeat (2) @(posedge ref_clk);
         stuck(w + 1);
         // synchroniser and edge detector need a few cycles after the last edge
         repeat (6) @(posedge ref_clk);
         mCnt = n;
         reg_read(ACn);
         reg_write(ACk, 8'h15);
         reg_read(ACn);
         reg_write(ASt, 8'h10);
      end
      reg_write(ACk, 8'h00);
      reg_write(AMd, 8'h00);
      reg_write(ASt, 8'h00);
      repeat (10) @(posedge ref_clk);
      reg_write(ASt, 8'h10);
      axi_read(ACn, rd);
      check({31'h0, (rd >= 10 && rd <= 24)}, 32'h1);
      $display("test clock sources done");
      end_of_test();
   end
endmodule
`default_nettype wire
